// File: rtl/dcsf_pkg.sv
// Shared constants and types for the deep 9-bit synchronous FIFO
package dcsf_pkg;

  // Word and storage geometry
  localparam int DATA_W        = 9;
  localparam int DEPTH_SMALL   = 16384;
  localparam int DEPTH_LARGE   = 32768;
  localparam int OFS_BYTE_W    = 8;
  localparam int OFS_W         = 2 * OFS_BYTE_W;

  // Threshold offset reset value, both flags
  localparam logic [OFS_BYTE_W-1:0] OFS_LO_RESET = 8'h07;
  localparam logic [OFS_BYTE_W-1:0] OFS_HI_RESET = 8'h00;

  // Offset register selection sequence
  localparam logic [1:0] SEL_EMPTY_LO = 2'h0;
  localparam logic [1:0] SEL_EMPTY_HI = 2'h1;
  localparam logic [1:0] SEL_FULL_LO  = 2'h2;
  localparam logic [1:0] SEL_FULL_HI  = 2'h3;

  // The four threshold offset bytes
  typedef struct packed {
    logic [OFS_BYTE_W-1:0] empty_lo;
    logic [OFS_BYTE_W-1:0] empty_hi;
    logic [OFS_BYTE_W-1:0] full_lo;
    logic [OFS_BYTE_W-1:0] full_hi;
  } dcsf_offsets_t;

  localparam dcsf_offsets_t OFS_RESET = '{
    empty_lo: OFS_LO_RESET,
    empty_hi: OFS_HI_RESET,
    full_lo:  OFS_LO_RESET,
    full_hi:  OFS_HI_RESET
  };

  // Status flags, all active low
  typedef struct packed {
    logic empty_n;
    logic full_n;
    logic almost_empty_n;
    logic almost_full_n;
  } dcsf_flags_t;

  localparam dcsf_flags_t FLAGS_RESET = '{
    empty_n:        1'b0,
    full_n:         1'b1,
    almost_empty_n: 1'b0,
    almost_full_n:  1'b1
  };

endpackage

// File: rtl/dcsf_store.sv
// Flip-flop storage array with one write port and one read index
`timescale 1ns/1ps
`default_nettype none

module dcsf_store #(
  parameter int DEPTH = dcsf_pkg::DEPTH_SMALL,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic                      clock,
  input  wire logic                      write_go,
  input  wire logic [AW-1:0]             write_index,
  input  wire logic [dcsf_pkg::DATA_W-1:0] write_word,
  input  wire logic [AW-1:0]             read_index,
  output logic      [dcsf_pkg::DATA_W-1:0] read_word
);

  logic [dcsf_pkg::DATA_W-1:0] cells [DEPTH];

  // One flop group per entry, loaded when its index is written
  for (genvar i = 0; i < DEPTH; i++) begin : g_cell
    always_ff @(posedge clock) begin
      if (write_go && (write_index == AW'(i))) begin
        cells[i] <= write_word;
      end
    end
  end

  // Word at the read pointer, registered by the caller
  assign read_word = cells[read_index];

endmodule

`default_nettype wire

// File: rtl/dcsf_fifo.sv
// Deep 9-bit FIFO with programmable almost-empty and almost-full flags
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Nine-bit words, 16K or 32K deep
// - Two-enable mode: primary low, secondary high, not full
// - Flag mode: primary enable gates writes while load is high
// - Mode pin sampled during reset selects function
// - Back-to-back writes accepted every cycle
// - Both read enables low, not empty: next word
// - Load asserted: write goes to selected offset
// - Load and read enables low: offset onto outputs
// - Empty flag low when no unread words
// - Full flag low when every location used
// - Almost-empty low when count at or below n
// - Almost-full low when free at or below m
// - Both offsets default to seven after reset
// - Offsets settable with one-word resolution
// - Flags change only on their clock edges
// - Each flag state holds at least one cycle
// - Output drive follows output enable low one clock edge later
// - Reset empties FIFO and clears pointers
// - Data outputs low after reset release
// - One clock serves both write and read ports
// - Offset bytes step cyclically through four registers
// - Offset access resumes at next register
// - Empty FIFO keeps last read word
module dcsf_fifo #(
  parameter int DEPTH = dcsf_pkg::DEPTH_SMALL,
  parameter int AW    = $clog2(DEPTH),
  parameter int CW    = AW + 1
) (
  input  wire logic                        clock,
  input  wire logic                        reset,
  input  wire logic [dcsf_pkg::DATA_W-1:0] write_data_in,
  input  wire logic                        write_enable_primary_n,
  input  wire logic                        write_enable_secondary_or_offset_load,
  input  wire logic                        read_enable_a_n,
  input  wire logic                        read_enable_b_n,
  input  wire logic                        output_enable_n,
  input  wire logic                        fifo_reset_n,
  output logic      [dcsf_pkg::DATA_W-1:0] read_data_out,
  output logic                             read_data_oe,
  output logic                             empty_flag_n,
  output logic                             full_flag_n,
  output logic                             almost_empty_flag_n,
  output logic                             almost_full_flag_n,
  output logic                             offset_program_mode
);

  // Registered state
  logic                          program_mode_q;
  logic [CW-1:0]                 write_ptr_q;
  logic [CW-1:0]                 read_ptr_q;
  logic [1:0]                    offset_sel_q;
  dcsf_pkg::dcsf_offsets_t       offsets_q;
  logic                          empty_n_q;
  logic                          full_n_q;
  logic                          almost_empty_n_q;
  logic                          almost_full_n_q;
  logic [dcsf_pkg::DATA_W-1:0]   read_data_q;
  logic                          read_data_oe_q;

  // Next-state and decode terms
  logic                          load_active;
  logic                          write_go;
  logic                          read_go;
  logic                          offset_write;
  logic                          offset_read;
  logic [CW-1:0]                 write_ptr_d;
  logic [CW-1:0]                 read_ptr_d;
  logic [CW-1:0]                 count_d;
  logic [dcsf_pkg::OFS_W:0]      count_wide;
  logic [dcsf_pkg::OFS_W:0]      free_wide;
  logic [dcsf_pkg::OFS_W:0]      empty_offset;
  logic [dcsf_pkg::OFS_W:0]      full_offset;
  dcsf_pkg::dcsf_flags_t         flags_d;
  logic [dcsf_pkg::OFS_BYTE_W-1:0] offset_byte;
  logic [dcsf_pkg::OFS_BYTE_W-1:0] offset_wr_byte;
  logic [dcsf_pkg::DATA_W-1:0]   store_word;

  // Load function only exists in programmable-flag mode
  assign load_active = program_mode_q && !write_enable_secondary_or_offset_load;

  // Data write: primary low with secondary (or load) high and not full
  assign write_go = fifo_reset_n
                    && !write_enable_primary_n
                    && write_enable_secondary_or_offset_load
                    && full_n_q;

  // Offset write replaces the array write while load is low
  assign offset_write = fifo_reset_n && load_active && !write_enable_primary_n;

  // Offset read takes the read port while load is low
  assign offset_read = fifo_reset_n && load_active
                       && !read_enable_a_n && !read_enable_b_n;

  // Data read: both read enables low, not empty, not loading
  assign read_go = fifo_reset_n && !load_active
                   && !read_enable_a_n && !read_enable_b_n
                   && empty_n_q;

  // Pointers advance modulo twice the depth, index is the low bits
  // The extra top bit keeps a full FIFO apart from an empty one
  assign write_ptr_d = write_ptr_q + CW'(write_go);
  assign read_ptr_d  = read_ptr_q + CW'(read_go);
  assign count_d     = write_ptr_d - read_ptr_d;

  // Offset bytes come from the low data bits; bit 8 is ignored
  assign offset_wr_byte = write_data_in[dcsf_pkg::OFS_BYTE_W-1:0];

  // Selected offset byte for reads
  always_comb begin
    case (offset_sel_q)
      dcsf_pkg::SEL_EMPTY_LO: offset_byte = offsets_q.empty_lo;
      dcsf_pkg::SEL_EMPTY_HI: offset_byte = offsets_q.empty_hi;
      dcsf_pkg::SEL_FULL_LO:  offset_byte = offsets_q.full_lo;
      dcsf_pkg::SEL_FULL_HI:  offset_byte = offsets_q.full_hi;
      default:                offset_byte = offsets_q.empty_lo;
    endcase
  end

  // Occupancy and free space at a common width wide enough for offsets
  always_comb begin
    count_wide   = (dcsf_pkg::OFS_W + 1)'(count_d);
    free_wide    = (dcsf_pkg::OFS_W + 1)'(DEPTH) - count_wide;
    empty_offset = {1'b0, offsets_q.empty_hi, offsets_q.empty_lo};
    full_offset  = {1'b0, offsets_q.full_hi, offsets_q.full_lo};
  end

  // Next flag levels from the post-edge occupancy
  // Using next-state pointers keeps the flags in step with the data
  always_comb begin
    flags_d.empty_n        = (count_d != '0);
    flags_d.full_n         = (count_wide != (dcsf_pkg::OFS_W + 1)'(DEPTH));
    flags_d.almost_empty_n = (count_wide > empty_offset);
    flags_d.almost_full_n  = (free_wide > full_offset);
  end

  // Storage array
  // Read index is the live pointer; the word is caught in read_data_q
  dcsf_store #(
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_store (
    .clock       (clock),
    .write_go    (write_go),
    .write_index (write_ptr_q[AW-1:0]),
    .write_word  (write_data_in),
    .read_index  (read_ptr_q[AW-1:0]),
    .read_word   (store_word)
  );

  // Mode strap caught while the FIFO reset pin is low
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      program_mode_q <= 1'b0;
    end else if (!fifo_reset_n) begin
      program_mode_q <= !write_enable_secondary_or_offset_load;
    end
  end

  // Write pointer, cleared by the FIFO reset pin
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      write_ptr_q <= '0;
    end else if (!fifo_reset_n) begin
      write_ptr_q <= '0;
    end else begin
      write_ptr_q <= write_ptr_d;
    end
  end

  // Read pointer, cleared by the FIFO reset pin
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      read_ptr_q <= '0;
    end else if (!fifo_reset_n) begin
      read_ptr_q <= '0;
    end else begin
      read_ptr_q <= read_ptr_d;
    end
  end

  // Offset selector: steps on each access, survives load release
  // A write and a read in one edge still step it only once
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      offset_sel_q <= dcsf_pkg::SEL_EMPTY_LO;
    end else if (!fifo_reset_n) begin
      offset_sel_q <= dcsf_pkg::SEL_EMPTY_LO;
    end else if (offset_write || offset_read) begin
      offset_sel_q <= offset_sel_q + 2'h1;
    end
  end

  // Offset bytes, written through the selector
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      offsets_q <= dcsf_pkg::OFS_RESET;
    end else if (!fifo_reset_n) begin
      offsets_q <= dcsf_pkg::OFS_RESET;
    end else if (offset_write) begin
      case (offset_sel_q)
        dcsf_pkg::SEL_EMPTY_LO: offsets_q.empty_lo <= offset_wr_byte;
        dcsf_pkg::SEL_EMPTY_HI: offsets_q.empty_hi <= offset_wr_byte;
        dcsf_pkg::SEL_FULL_LO:  offsets_q.full_lo  <= offset_wr_byte;
        dcsf_pkg::SEL_FULL_HI:  offsets_q.full_hi  <= offset_wr_byte;
        default:                offsets_q          <= offsets_q;
      endcase
    end
  end

  // Empty flag, registered on the read side
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      empty_n_q <= dcsf_pkg::FLAGS_RESET.empty_n;
    end else if (!fifo_reset_n) begin
      empty_n_q <= dcsf_pkg::FLAGS_RESET.empty_n;
    end else begin
      empty_n_q <= flags_d.empty_n;
    end
  end

  // Full flag, registered on the write side
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      full_n_q <= dcsf_pkg::FLAGS_RESET.full_n;
    end else if (!fifo_reset_n) begin
      full_n_q <= dcsf_pkg::FLAGS_RESET.full_n;
    end else begin
      full_n_q <= flags_d.full_n;
    end
  end

  // Almost-empty flag, registered on the read side
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      almost_empty_n_q <= dcsf_pkg::FLAGS_RESET.almost_empty_n;
    end else if (!fifo_reset_n) begin
      almost_empty_n_q <= dcsf_pkg::FLAGS_RESET.almost_empty_n;
    end else begin
      almost_empty_n_q <= flags_d.almost_empty_n;
    end
  end

  // Almost-full flag, registered on the write side
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      almost_full_n_q <= dcsf_pkg::FLAGS_RESET.almost_full_n;
    end else if (!fifo_reset_n) begin
      almost_full_n_q <= dcsf_pkg::FLAGS_RESET.almost_full_n;
    end else begin
      almost_full_n_q <= flags_d.almost_full_n;
    end
  end

  // Output word: new data word, offset byte, or held last word
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      read_data_q <= '0;
    end else if (!fifo_reset_n) begin
      read_data_q <= '0;
    end else if (offset_read) begin
      read_data_q <= {1'b0, offset_byte};
    end else if (read_go) begin
      read_data_q <= store_word;
    end
  end

  // Output enable, registered from the active-low pin
  // Registered like the word so drive and data change on one edge
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      read_data_oe_q <= 1'b0;
    end else begin
      read_data_oe_q <= !output_enable_n;
    end
  end

  // Ports come straight from flops
  assign read_data_out       = read_data_q;
  assign read_data_oe        = read_data_oe_q;
  assign empty_flag_n        = empty_n_q;
  assign full_flag_n         = full_n_q;
  assign almost_empty_flag_n = almost_empty_n_q;
  assign almost_full_flag_n  = almost_full_n_q;
  assign offset_program_mode = program_mode_q;

endmodule

`default_nettype wire

// File: tb/dcsf_fifo_sva.sv
// Port-level assertions for the deep FIFO
`timescale 1ns/1ps
`default_nettype none
module dcsf_fifo_sva (
  input wire logic       clock,
  input wire logic       reset,
  input wire logic       write_enable_primary_n,
  input wire logic       write_enable_secondary_or_offset_load,
  input wire logic       read_enable_a_n,
  input wire logic       read_enable_b_n,
  input wire logic       output_enable_n,
  input wire logic       fifo_reset_n,
  input wire logic [8:0] read_data_out,
  input wire logic       read_data_oe,
  input wire logic       empty_flag_n,
  input wire logic       full_flag_n,
  input wire logic       almost_empty_flag_n,
  input wire logic       almost_full_flag_n,
  input wire logic       offset_program_mode
);
  // Decoded port activity
  wire logic ld = offset_program_mode && !write_enable_secondary_or_offset_load;
  wire logic wr = !write_enable_primary_n && write_enable_secondary_or_offset_load;
  wire logic rd = !read_enable_a_n && !read_enable_b_n && !ld;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  chk_oe_lag:
    assert property (!reset |=> read_data_oe == !$past(output_enable_n))
      else $error("data drive enable does not follow the output enable");
  chk_reset_flags:
    assert property (!fifo_reset_n |=> {empty_flag_n, full_flag_n, almost_empty_flag_n,
      almost_full_flag_n} == 4'h5) else $error("fifo reset left a flag wrong");
  chk_reset_data:
    assert property (!fifo_reset_n |=> read_data_out == 9'h000)
      else $error("fifo reset left the data outputs high");
  chk_mode_latch:
    assert property (!fifo_reset_n |=> offset_program_mode ==
      !$past(write_enable_secondary_or_offset_load)) else $error("mode not latched");
  chk_empty_keep:
    assert property (fifo_reset_n && !empty_flag_n && !ld |=> $stable(read_data_out))
      else $error("data outputs moved while empty");
  chk_empty_leave:
    assert property (fifo_reset_n && !empty_flag_n && wr |=> empty_flag_n)
      else $error("empty flag stayed low after a write");
  chk_full_stay:
    assert property (fifo_reset_n && !full_flag_n && !(rd && empty_flag_n) |=> !full_flag_n)
      else $error("full flag released with no read");
  chk_ae_below:
    assert property (!empty_flag_n |-> !almost_empty_flag_n)
      else $error("almost empty high while empty");
  chk_af_below:
    assert property (!full_flag_n |-> !almost_full_flag_n)
      else $error("almost full high while full");
  // Main scenarios reached
  cover property (!full_flag_n);
  cover property (ld && !write_enable_primary_n);
  cover property (rd && empty_flag_n && !almost_empty_flag_n);
endmodule
`default_nettype wire

// File: tb/dcsf_peer.sv
// Producer and consumer model on the FIFO's write and read ports
`timescale 1ns/1ps
`default_nettype none
module dcsf_peer (
  input  wire logic      clock,
  input  wire logic      reset,
  input  wire logic      fifo_reset_n,
  input  wire logic      full_flag_n,
  input  wire logic      empty_flag_n,
  input  wire logic      offset_program_mode,
  output var logic [8:0] write_data_in,
  output var logic       write_enable_primary_n,
  output var logic       write_enable_secondary_or_offset_load,
  output var logic       read_enable_a_n,
  output var logic       read_enable_b_n
);
  logic [8:0] q [$];
  logic [8:0] exp_word;
  // Idle levels from time zero
  initial begin
    write_data_in = 9'h000;
    write_enable_primary_n = 1'b1;
    write_enable_secondary_or_offset_load = 1'b1;
    read_enable_a_n = 1'b1;
    read_enable_b_n = 1'b1;
  end
  // Words accepted and the word each read hands out
  always @(posedge clock or posedge reset) begin
    if (reset || !fifo_reset_n) begin
      q.delete();
      exp_word = 9'h000;
    end else begin
      if (!read_enable_a_n && !read_enable_b_n && empty_flag_n && q.size() > 0 &&
          !(offset_program_mode && !write_enable_secondary_or_offset_load))
        exp_word = q.pop_front();
      if (!write_enable_primary_n && write_enable_secondary_or_offset_load && full_flag_n)
        q.push_back(write_data_in);
    end
  end
  // Hold enables for n edges, second enable from expansion side
  task automatic drive(input int n, input logic [8:0] base, input logic w, s, r);
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      write_data_in <= base + i[8:0];
      write_enable_primary_n <= !w;
      write_enable_secondary_or_offset_load <= s;
      read_enable_a_n <= !r;
      read_enable_b_n <= !r;
    end
    @(posedge clock);
    write_data_in <= ~write_data_in;
    write_enable_primary_n <= 1'b1;
    write_enable_secondary_or_offset_load <= 1'b1;
    read_enable_a_n <= 1'b1;
    read_enable_b_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the deep FIFO
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int DEPTH = 16;
  logic       clock, reset, fifo_reset_n, output_enable_n;
  wire  [8:0] write_data_in, read_data_out;
  wire        write_enable_primary_n, write_enable_secondary_or_offset_load;
  wire        read_enable_a_n, read_enable_b_n, read_data_oe, offset_program_mode;
  wire        empty_flag_n, full_flag_n, almost_empty_flag_n, almost_full_flag_n;
  int         err_count = 0;
  int         tests_run = 0;
  dcsf_fifo #(.DEPTH(DEPTH)) uut (
    .clock                                 (clock),
    .reset                                 (reset),
    .write_data_in                         (write_data_in),
    .write_enable_primary_n                (write_enable_primary_n),
    .write_enable_secondary_or_offset_load (write_enable_secondary_or_offset_load),
    .read_enable_a_n                       (read_enable_a_n),
    .read_enable_b_n                       (read_enable_b_n),
    .output_enable_n                       (output_enable_n),
    .fifo_reset_n                          (fifo_reset_n),
    .read_data_out                         (read_data_out),
    .read_data_oe                          (read_data_oe),
    .empty_flag_n                          (empty_flag_n),
    .full_flag_n                           (full_flag_n),
    .almost_empty_flag_n                   (almost_empty_flag_n),
    .almost_full_flag_n                    (almost_full_flag_n),
    .offset_program_mode                   (offset_program_mode)
  );
  dcsf_peer u_peer (
    .clock                                 (clock),
    .reset                                 (reset),
    .fifo_reset_n                          (fifo_reset_n),
    .full_flag_n                           (full_flag_n),
    .empty_flag_n                          (empty_flag_n),
    .offset_program_mode                   (offset_program_mode),
    .write_data_in                         (write_data_in),
    .write_enable_primary_n                (write_enable_primary_n),
    .write_enable_secondary_or_offset_load (write_enable_secondary_or_offset_load),
    .read_enable_a_n                       (read_enable_a_n),
    .read_enable_b_n                       (read_enable_b_n)
  );
  // One shared clock for both ports
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic flags(input logic e, f, ae, af);
    repeat (2) @(negedge clock);
    check({empty_flag_n, full_flag_n, almost_empty_flag_n, almost_full_flag_n}, {e, f, ae, af});
  endtask
  task automatic watch(input int n);
    repeat (n) begin
      @(negedge clock);
      check(read_data_out, u_peer.exp_word);
    end
  endtask
  task automatic t_reset(input logic sec);
    @(posedge clock);
    fifo_reset_n <= 1'b0;
    u_peer.write_enable_secondary_or_offset_load <= sec;
    repeat (2) @(posedge clock);
    fifo_reset_n <= 1'b1;
    u_peer.write_enable_secondary_or_offset_load <= 1'b1;
    flags(1'b0, 1'b1, 1'b0, 1'b1);
    check(read_data_out, 32'h0);
    check(offset_program_mode, !sec);
    $display("test reset done");
  endtask
  task automatic t_thresh(input int n, input logic [8:0] base);
    u_peer.drive(n, base, 1'b1, 1'b1, 1'b0);
    flags(1'b1, 1'b1, 1'b0, 1'b1);
    u_peer.drive(1, ~base, 1'b1, 1'b1, 1'b0);
    flags(1'b1, 1'b1, 1'b1, 1'b1);
    fork
      u_peer.drive(n + 1, 9'h000, 1'b0, 1'b1, 1'b1);
    join_none
    watch(n + 4);
    flags(1'b0, 1'b1, 1'b0, 1'b1);
    $display("test threshold done");
  endtask
  task automatic t_fill;
    u_peer.drive(2, 9'h1aa, 1'b1, 1'b0, 1'b0);
    flags(1'b0, 1'b1, 1'b0, 1'b1);
    u_peer.drive(8, 9'h100, 1'b1, 1'b1, 1'b0);
    flags(1'b1, 1'b1, 1'b1, 1'b1);
    u_peer.drive(1, 9'h155, 1'b1, 1'b1, 1'b0);
    flags(1'b1, 1'b1, 1'b1, 1'b0);
    u_peer.drive(DEPTH, 9'h0c0, 1'b1, 1'b1, 1'b0);
    flags(1'b1, 1'b0, 1'b1, 1'b0);
    check(u_peer.q.size(), DEPTH);
    $display("test fill done");
  endtask
  task automatic t_drain;
    fork
      u_peer.drive(DEPTH + 2, 9'h000, 1'b0, 1'b1, 1'b1);
    join_none
    watch(DEPTH + 5);
    flags(1'b0, 1'b1, 1'b0, 1'b1);
    $display("test drain done");
  endtask
  task automatic t_oe;
    for (int i = 1; i >= 0; i--) begin
      @(posedge clock);
      output_enable_n <= i[0];
      repeat (2) @(negedge clock);
      check(read_data_oe, !i[0]);
    end
    $display("test output enable done");
  endtask
  task automatic t_prog;
    logic [8:0] ofs [4];
    ofs = '{9'h003, 9'h000, 9'h004, 9'h000};
    foreach (ofs[i]) u_peer.drive(1, ofs[i], 1'b1, 1'b0, 1'b0);
    foreach (ofs[i]) begin
      u_peer.drive(1, 9'h000, 1'b0, 1'b0, 1'b1);
      @(negedge clock);
      check(read_data_out, ofs[i]);
    end
    $display("test offsets done");
  endtask
  task automatic close_out;
    $display("tests_run=%0d err_count=%0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    reset = 1'b1;
    fifo_reset_n = 1'b0;
    output_enable_n = 1'b0;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    t_reset(1'b1);
    t_thresh(7, 9'h040);
    t_fill;
    t_drain;
    t_oe;
    t_reset(1'b0);
    t_prog;
    t_thresh(3, 9'h020);
    close_out;
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    close_out;
  end
endmodule
bind dcsf_fifo dcsf_fifo_sva u_sva (
  .clock                                 (clock),
  .reset                                 (reset),
  .write_enable_primary_n                (write_enable_primary_n),
  .write_enable_secondary_or_offset_load (write_enable_secondary_or_offset_load),
  .read_enable_a_n                       (read_enable_a_n),
  .read_enable_b_n                       (read_enable_b_n),
  .output_enable_n                       (output_enable_n),
  .fifo_reset_n                          (fifo_reset_n),
  .read_data_out                         (read_data_out),
  .read_data_oe                          (read_data_oe),
  .empty_flag_n                          (empty_flag_n),
  .full_flag_n                           (full_flag_n),
  .almost_empty_flag_n                   (almost_empty_flag_n),
  .almost_full_flag_n                    (almost_full_flag_n),
  .offset_program_mode                   (offset_program_mode)
);
`default_nettype wire
